// ===== uart_baud_break_control_tb.sv
// self-checking bench for the baud/break control block
`timescale 1ns/100ps
`include "ubk_defs.svh"
module uart_baud_break_control_tb;
    logic clk = 1'b0, resetn = 1'b0, wr = 1'b0, rd = 1'b0, tx_data = 1'b1;
    logic ext_pin = 1'b1, cap_pin = 1'b1, use_alt = 1'b0;
    logic [15:0] addr = 16'h0000;
    logic [7:0] wdata = 8'h00, rdata, low_bits, v;
    logic baud_tick, tx_def, tx_alt, oe_def_n, oe_alt_n, rx_data, ext_out, cap_out, fbs, irq, rx_def, rx_alt;
    int fail_count = 0, num_checks = 0, cyc = 0;
    ubk_top ubk_top_inst (.clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .base_clk_tick(1'b1), .serial_tx_data(tx_data), .rx_pin_default(rx_def),
        .rx_pin_alt(rx_alt), .ext_irq_pin(ext_pin), .capture_pin(cap_pin), .baud_tick(baud_tick),
        .tx_pin_default(tx_def), .tx_pin_alt(tx_alt), .tx_pin_default_oe_n(oe_def_n),
        .tx_pin_alt_oe_n(oe_alt_n), .serial_rx_data(rx_data), .external_irq_input(ext_out),
        .timer_capture_input(cap_out), .first_bit_select(fbs), .irq(irq));
    ubk_lin_node ubk_lin_node_inst (.clk(clk), .baud_tick(baud_tick), .use_alt(use_alt),
        .tx_line(use_alt ? tx_alt : tx_def), .rx_default(rx_def), .rx_alt(rx_alt), .tx_low_bits(low_bits));
    // --------------------------------------------------------------
    // bus and compare tasks
    // --------------------------------------------------------------
    initial forever #20 clk = ~clk;
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic wreg(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rreg(input logic [15:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask
    task automatic rchk(input string name, input logic [15:0] a, input logic [7:0] exp);
        rreg(a, v);
        chk(name, {8'h00, exp}, {8'h00, v});
    endtask
    task automatic wait_irq();
        int n;
        for (n = 0; n < 600 && irq !== 1'b1; n++) @(posedge clk);
        // let the node publish the run it timed
        #1;
        chk("irq", 16'h0001, {15'h0000, irq});
    endtask
    // cycles between two baud ticks
    task automatic period(input logic [15:0] exp);
        int n;
        for (n = 0; n < 600 && baud_tick !== 1'b1; n++) @(posedge clk);
        @(posedge clk);
        for (n = 1; n < 600 && baud_tick !== 1'b1; n++) @(posedge clk);
        chk("bit_period", exp, n[15:0]);
    endtask
    // --------------------------------------------------------------
    // scenarios
    // --------------------------------------------------------------
    task automatic t_reset();
        rchk("divider", `UBK_ADDR_DIV, 8'hff);
        rchk("break_ctl", `UBK_ADDR_BRK, 8'h16);
        rchk("in_switch", `UBK_ADDR_ISW, 8'h00);
        rchk("unmapped", 16'hff00, 8'h00);
        chk("first_bit", 16'h0001, {15'h0000, fbs});
    endtask
    task automatic t_baud();
        wreg(`UBK_ADDR_MODE, 8'h04);
        period(16'd510);
        wreg(`UBK_ADDR_MODE, 8'h00);
        wreg(`UBK_ADDR_DIV, 8'h03);
        rchk("div_low", `UBK_ADDR_DIV, 8'hff);
        wreg(`UBK_ADDR_DIV, 8'h04);
        rchk("div_min", `UBK_ADDR_DIV, 8'h04);
        wreg(`UBK_ADDR_MODE, 8'h04);
        period(16'd8);
        wreg(`UBK_ADDR_MODE, 8'h00);
    endtask
    task automatic t_break_tx();
        logic [2:0] c;
        wreg(`UBK_ADDR_MSK, 8'h01);
        wreg(`UBK_ADDR_MODE, 8'h06);
        for (int i = 0; i < 8; i++) begin
            c = i[2:0];
            wreg(`UBK_ADDR_BRK, {3'b001, c, 2'b10});
            wait_irq();
            chk("break_len", (c >= 3'd5) ? 16'd8 + c : 16'd16 + c, {8'h00, low_bits});
            rchk("status_tx", `UBK_ADDR_IST, 8'h01);
            // irq follows the status one cycle later
            @(posedge clk);
            #1;
            chk("irq_clear", 16'h0000, {15'h0000, irq});
            rchk("tx_trig", `UBK_ADDR_BRK, {3'b000, c, 2'b10});
        end
        wreg(`UBK_ADDR_MODE, 8'h00);
        wreg(`UBK_ADDR_BRK, 8'h16);
    endtask
    task automatic t_invert();
        wreg(`UBK_ADDR_BRK, 8'h15);
        tx_data <= 1'b0;
        repeat (3) @(posedge clk);
        chk("tx_inv", 16'h0001, {15'h0000, tx_def});
        chk("tx_oe_n", 16'h0000, {15'h0000, oe_def_n});
        chk("first_bit", 16'h0000, {15'h0000, fbs});
        tx_data <= 1'b1;
        repeat (3) @(posedge clk);
        chk("tx_inv", 16'h0000, {15'h0000, tx_def});
        wreg(`UBK_ADDR_BRK, 8'h16);
    endtask
    task automatic t_break_rx();
        wreg(`UBK_ADDR_ISW, 8'h08);
        wreg(`UBK_ADDR_MSK, 8'h00);
        wreg(`UBK_ADDR_MODE, 8'h05);
        wreg(`UBK_ADDR_BRK, 8'h56);
        rchk("rx_busy", `UBK_ADDR_BRK, 8'h96);
        ubk_lin_node_inst.send_low(5);
        repeat (40) @(posedge clk);
        rchk("rx_error", `UBK_ADDR_BRK, 8'h96);
        ubk_lin_node_inst.send_low(12);
        repeat (40) @(posedge clk);
        rchk("rx_done", `UBK_ADDR_BRK, 8'h16);
        chk("irq_masked", 16'h0000, {15'h0000, irq});
        rchk("status_rx", `UBK_ADDR_IST, 8'h02);
        rchk("status_rc", `UBK_ADDR_IST, 8'h00);
        wreg(`UBK_ADDR_MODE, 8'h00);
    endtask
    task automatic t_route();
        wreg(`UBK_ADDR_ISW, 8'h00);
        ubk_lin_node_inst.drive(1'b0);
        ext_pin <= 1'b0;
        // filter settles well inside this wait
        repeat (10) @(posedge clk);
        chk("rx_gated", 16'h0001, {15'h0000, rx_data});
        chk("irq_pin", 16'h0000, {15'h0000, ext_out});
        chk("cap_pin", 16'h0001, {15'h0000, cap_out});
        ext_pin <= 1'b1;
        wreg(`UBK_ADDR_ISW, 8'h0b);
        repeat (10) @(posedge clk);
        chk("rx_open", 16'h0000, {15'h0000, rx_data});
        chk("irq_route", 16'h0000, {15'h0000, ext_out});
        chk("cap_route", 16'h0000, {15'h0000, cap_out});
        wreg(`UBK_ADDR_ISW, 8'h3b);
        use_alt <= 1'b1;
        repeat (10) @(posedge clk);
        chk("rx_alt", 16'h0000, {15'h0000, rx_data});
        ubk_lin_node_inst.drive(1'b1);
        repeat (10) @(posedge clk);
        chk("rx_alt_hi", 16'h0001, {15'h0000, cap_out});
        wreg(`UBK_ADDR_MODE, 8'h06);
        repeat (3) @(posedge clk);
        chk("tx_alt_oe_n", 16'h0000, {15'h0000, oe_alt_n});
        chk("tx_def_oe_n", 16'h0001, {15'h0000, oe_def_n});
        chk("tx_alt", 16'h0001, {15'h0000, tx_alt});
        wreg(`UBK_ADDR_MODE, 8'h00);
        use_alt <= 1'b0;
        wreg(`UBK_ADDR_ISW, 8'h00);
    endtask
    // --------------------------------------------------------------
    // run control
    // --------------------------------------------------------------
    task automatic close_out();
        if (fail_count == 0 && num_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 30000) begin
            fail_count++;
            close_out();
        end
    end
    initial begin
        repeat (10) @(posedge clk);
        resetn <= 1'b1;
        t_reset();
        t_baud();
        t_break_tx();
        t_invert();
        t_break_rx();
        t_route();
        close_out();
    end
endmodule // uart_baud_break_control_tb

// ===== ubk_defs.svh
// constants and operation summary for the baud/break control block
// Operation
// RULE_01: divide base clock by k, 4 to 255
// RULE_02: bit rate is counter output halved
// RULE_03: divider resets to all ones
// RULE_04: software rewrites divider only while idle
// RULE_05: break control resets to 0x16, msb read-only
// RULE_06: rx status set during break reception
// RULE_07: break error returns to reception, flag held
// RULE_08: rx trigger starts reception, reads zero
// RULE_09: tx trigger starts break send, reads zero
// RULE_10: break width 13 to 20 bit times
// RULE_11: first-bit select and tx inversion
// RULE_12: software changes order/inversion only while idle
// RULE_13: inversion keeps tx pin on serial output
// RULE_14: rx trigger only with power and rx enable
// RULE_15: tx trigger only with power and tx enable
// RULE_16: no retrigger during operation or refresh
// RULE_17: pin swap selects alternate pin pair
// RULE_18: default rx pin gated by input enable
// RULE_19: route bits feed irq and capture inputs
`ifndef UBK_DEFS_SVH
`define UBK_DEFS_SVH
`define UBK_ADDR_DIV 16'hff57
`define UBK_ADDR_BRK 16'hff58
`define UBK_ADDR_ISW 16'hff4f
`define UBK_ADDR_IST 16'hff50
`define UBK_ADDR_MSK 16'hff51
`define UBK_ADDR_MODE 16'hff52
`define UBK_DIV_RST 8'hff
`define UBK_BRK_RST 8'h16
`define UBK_ISW_RST 8'h00
`define UBK_DIV_MIN 8'h04
`define UBK_BIT_RXST 7
`define UBK_BIT_RXTRG 6
`define UBK_BIT_TXTRG 5
`define UBK_BIT_DIR 1
`define UBK_BIT_INV 0
`define UBK_BRK_BASE 5'h0d
`define UBK_BRK_CODE0 3'h5
`define UBK_BRK_MAX 5'h14
`define UBK_RXBRK_MIN 5'h0b
`define UBK_SWAP_A 5
`define UBK_SWAP_B 4
`define UBK_RXEN 3
`define UBK_CAP 1
`define UBK_IRQ 0
`endif

// ===== ubk_lin_node.sv
// remote serial node model: drives the receive line, times break fields seen on transmit
`timescale 1ns/100ps
module ubk_lin_node (
    input wire logic clk,
    input wire logic baud_tick,
    input wire logic use_alt,
    input wire logic tx_line,
    output logic rx_default,
    output logic rx_alt,
    output logic [7:0] tx_low_bits
);
    logic line_reg = 1'b1;
    logic [7:0] run_reg = 8'h00;
    // --------------------------------------------------------------
    // line drive
    // --------------------------------------------------------------
    // the pin not in use floats to its pull-up, never the last value
    assign rx_default = use_alt ? 1'b1 : line_reg;
    assign rx_alt = use_alt ? line_reg : 1'b1;
    // bit times follow the device tick; a real node runs its own clock
    always @(posedge clk) begin
        if (!tx_line) begin
            if (baud_tick) run_reg <= run_reg + 8'h01;
        end else if (run_reg != 8'h00) begin
            tx_low_bits <= run_reg;
            run_reg <= 8'h00;
        end
    end
    task automatic drive(input logic v);
        @(posedge clk);
        line_reg <= v;
    endtask
    task automatic send_low(input int n);
        drive(1'b0);
        repeat (n) @(posedge clk iff baud_tick);
        line_reg <= 1'b1;
    endtask
endmodule // ubk_lin_node

// ===== ubk_pkg.sv
// types for the baud/break control block
package ubk_pkg;
    typedef enum logic [1:0] {ubk_idle, ubk_tx_brk, ubk_rx_wait, ubk_rx_low} ubk_state_e;
endpackage

// ===== ubk_top.sv
// baud generator, break send/receive control and input routing
`timescale 1ns/100ps
`include "ubk_defs.svh"
module ubk_top (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [15:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    input wire logic base_clk_tick,
    input wire logic serial_tx_data,
    input wire logic rx_pin_default,
    input wire logic rx_pin_alt,
    input wire logic ext_irq_pin,
    input wire logic capture_pin,
    output logic baud_tick,
    output logic tx_pin_default,
    output logic tx_pin_alt,
    output logic tx_pin_default_oe_n,
    output logic tx_pin_alt_oe_n,
    output logic serial_rx_data,
    output logic external_irq_input,
    output logic timer_capture_input,
    output logic first_bit_select,
    output logic irq
);
    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [7:0] baud_divider_reg;
    logic [7:0] break_control_reg;
    logic [7:0] input_switch_reg;
    logic [2:0] mode_reg; // power, tx enable, rx enable
    logic [1:0] ist_reg;  // bit0 break sent, bit1 break received
    logic [1:0] msk_reg;
    ubk_pkg::ubk_state_e state_reg;
    logic [7:0] div_cnt_reg;
    logic half_reg;
    logic [4:0] bit_cnt_reg;
    logic [2:0] rxs_reg;
    logic rx_level_reg;
    logic [2:0] ext_s_reg;
    logic [2:0] cap_s_reg;
    logic ev_tx_done, ev_rx_done;
    logic power, txe, rxe;
    logic rx_sel;
    assign power = mode_reg[2];
    assign txe = mode_reg[1];
    assign rxe = mode_reg[0];
    logic sel_div, sel_brk, sel_isw, sel_ist, sel_msk, sel_mode;
    assign sel_div = addr == `UBK_ADDR_DIV;
    assign sel_brk = addr == `UBK_ADDR_BRK;
    assign sel_isw = addr == `UBK_ADDR_ISW;
    assign sel_ist = addr == `UBK_ADDR_IST;
    assign sel_msk = addr == `UBK_ADDR_MSK;
    assign sel_mode = addr == `UBK_ADDR_MODE;
    // a break starts on a fresh bit time so its length is whole bit times
    logic brk_restart;
    assign brk_restart = wr && sel_brk && wdata[`UBK_BIT_TXTRG] && power && txe && state_reg == ubk_pkg::ubk_idle;

    // ------------------------------------------------------------
    // register writes
    // ------------------------------------------------------------
    // divider writes below k=4 are ignored so the counter never stalls
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            baud_divider_reg <= `UBK_DIV_RST; // RULE_03
        end else if (wr && sel_div && wdata >= `UBK_DIV_MIN) begin
            baud_divider_reg <= wdata; // RULE_01
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            input_switch_reg <= `UBK_ISW_RST; // RULE_18
            msk_reg <= 2'h0;
            mode_reg <= 3'h0;
        end else begin
            if (wr && sel_isw) input_switch_reg <= {2'h0, wdata[5:0]};
            if (wr && sel_msk) msk_reg <= wdata[1:0];
            if (wr && sel_mode) mode_reg <= wdata[2:0];
        end
    end

    // bits 6..0 writable, bit 7 owned by hardware; triggers self-clear
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            break_control_reg <= `UBK_BRK_RST; // RULE_05
        end else begin
            if (wr && sel_brk) begin
                break_control_reg[6:0] <= wdata[6:0]; // RULE_05
            end else begin
                if (ev_tx_done) break_control_reg[`UBK_BIT_TXTRG] <= 1'b0; // RULE_09
                if (ev_rx_done) break_control_reg[`UBK_BIT_RXTRG] <= 1'b0; // RULE_08
            end
            if (state_reg == ubk_pkg::ubk_rx_wait || state_reg == ubk_pkg::ubk_rx_low) begin
                break_control_reg[`UBK_BIT_RXST] <= 1'b1; // RULE_06 RULE_07
            end
            if (ev_rx_done || (!power && !rxe)) begin
                break_control_reg[`UBK_BIT_RXST] <= 1'b0; // RULE_06
            end
        end
    end

    // ------------------------------------------------------------
    // baud generator
    // ------------------------------------------------------------
    // counter output toggles a half flag; a bit time is two outputs
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            div_cnt_reg <= 8'h00;
            half_reg <= 1'b0;
            baud_tick <= 1'b0;
        end else begin
            baud_tick <= 1'b0;
            if (!power || brk_restart) begin
                div_cnt_reg <= 8'h00;
                half_reg <= 1'b0;
            end else if (base_clk_tick) begin
                if (div_cnt_reg >= baud_divider_reg - 8'h01) begin // RULE_01
                    div_cnt_reg <= 8'h00;
                    half_reg <= ~half_reg;
                    baud_tick <= half_reg; // RULE_02
                end else begin
                    div_cnt_reg <= div_cnt_reg + 8'h01;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // input synchronisers and pin routing
    // ------------------------------------------------------------
    // the default pin reads as idle high while its input enable is clear, never as a break; the alternate pin is not gated
    assign rx_sel = input_switch_reg[`UBK_SWAP_A] | input_switch_reg[`UBK_SWAP_B] ? rx_pin_alt
                    : (rx_pin_default | ~input_switch_reg[`UBK_RXEN]); // RULE_17 RULE_18
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rxs_reg <= 3'h7;
            ext_s_reg <= 3'h0;
            cap_s_reg <= 3'h0;
            rx_level_reg <= 1'b1;
        end else begin
            rxs_reg <= {rxs_reg[1:0], rx_sel};
            ext_s_reg <= {ext_s_reg[1:0], ext_irq_pin};
            cap_s_reg <= {cap_s_reg[1:0], capture_pin};
            if (rxs_reg[2] == rxs_reg[1]) rx_level_reg <= rxs_reg[2];
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            serial_rx_data <= 1'b1;
            external_irq_input <= 1'b0;
            timer_capture_input <= 1'b0;
            first_bit_select <= 1'b0;
        end else begin
            serial_rx_data <= rx_level_reg;
            // pins count a change only once the last two stages agree
            if (input_switch_reg[`UBK_IRQ]) external_irq_input <= rx_level_reg; // RULE_19
            else if (ext_s_reg[2] == ext_s_reg[1]) external_irq_input <= ext_s_reg[2];
            if (input_switch_reg[`UBK_CAP]) timer_capture_input <= rx_level_reg; // RULE_19
            else if (cap_s_reg[2] == cap_s_reg[1]) timer_capture_input <= cap_s_reg[2];
            first_bit_select <= break_control_reg[`UBK_BIT_DIR]; // RULE_11
        end
    end

    // ------------------------------------------------------------
    // break send / receive
    // ------------------------------------------------------------
    logic [4:0] brk_len;
    // the width code wraps: the reset code gives the shortest break
    assign brk_len = `UBK_BRK_BASE + {2'h0, break_control_reg[4:2] - `UBK_BRK_CODE0}; // RULE_10
    logic tx_start, rx_start;
    assign tx_start = wr && sel_brk && wdata[`UBK_BIT_TXTRG] && power && txe;
    assign rx_start = wr && sel_brk && wdata[`UBK_BIT_RXTRG] && power && rxe;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_reg <= ubk_pkg::ubk_idle;
            bit_cnt_reg <= 5'h00;
        end else begin
            case (state_reg)
                ubk_pkg::ubk_idle: begin
                    bit_cnt_reg <= 5'h00;
                    if (tx_start) state_reg <= ubk_pkg::ubk_tx_brk; // RULE_09
                    else if (rx_start) state_reg <= ubk_pkg::ubk_rx_wait; // RULE_08
                end
                ubk_pkg::ubk_tx_brk: begin
                    if (!power || !txe) state_reg <= ubk_pkg::ubk_idle;
                    else if (baud_tick) begin
                        if (bit_cnt_reg == brk_len - 5'h01) state_reg <= ubk_pkg::ubk_idle; // RULE_10
                        bit_cnt_reg <= bit_cnt_reg + 5'h01;
                    end
                end
                ubk_pkg::ubk_rx_wait: begin
                    bit_cnt_reg <= 5'h00;
                    if (!power || !rxe) state_reg <= ubk_pkg::ubk_idle;
                    else if (!rx_level_reg) state_reg <= ubk_pkg::ubk_rx_low;
                end
                ubk_pkg::ubk_rx_low: begin
                    if (!power || !rxe) state_reg <= ubk_pkg::ubk_idle;
                    else if (rx_level_reg) begin
                        if (bit_cnt_reg >= `UBK_RXBRK_MIN) state_reg <= ubk_pkg::ubk_idle;
                        else state_reg <= ubk_pkg::ubk_rx_wait; // RULE_07
                    end else if (baud_tick && bit_cnt_reg != 5'h1f) begin
                        bit_cnt_reg <= bit_cnt_reg + 5'h01;
                    end
                end
                default: state_reg <= ubk_pkg::ubk_idle;
            endcase
        end
    end
    assign ev_tx_done = state_reg == ubk_pkg::ubk_tx_brk && baud_tick && power && txe
                        && bit_cnt_reg == brk_len - 5'h01;
    assign ev_rx_done = state_reg == ubk_pkg::ubk_rx_low && power && rxe && rx_level_reg
                        && bit_cnt_reg >= `UBK_RXBRK_MIN;

    // ------------------------------------------------------------
    // transmit pin
    // ------------------------------------------------------------
    // serial output owns the pin when enabled, or always while inverted
    logic tx_line, tx_own, swap;
    assign tx_line = (state_reg == ubk_pkg::ubk_tx_brk ? 1'b0 : serial_tx_data)
                     ^ break_control_reg[`UBK_BIT_INV]; // RULE_11
    assign tx_own = (power && txe) || break_control_reg[`UBK_BIT_INV]; // RULE_13
    assign swap = input_switch_reg[`UBK_SWAP_A] | input_switch_reg[`UBK_SWAP_B];
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            tx_pin_default <= 1'b1;
            tx_pin_alt <= 1'b1;
            tx_pin_default_oe_n <= 1'b1;
            tx_pin_alt_oe_n <= 1'b1;
        end else begin
            tx_pin_default <= tx_line;
            tx_pin_alt <= tx_line;
            tx_pin_default_oe_n <= !(tx_own && !swap); // RULE_17
            tx_pin_alt_oe_n <= !(tx_own && swap); // RULE_17
        end
    end

    // ------------------------------------------------------------
    // interrupts and read-back
    // ------------------------------------------------------------
    // set wins over the read-clear
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ist_reg <= 2'h0;
            irq <= 1'b0;
        end else begin
            ist_reg <= (rd && sel_ist ? 2'h0 : ist_reg) | {ev_rx_done, ev_tx_done};
            irq <= |(ist_reg & msk_reg);
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rdata <= 8'h00;
        end else if (rd) begin
            if (sel_div) rdata <= baud_divider_reg;
            else if (sel_brk) rdata <= break_control_reg & 8'h9f; // RULE_08 RULE_09
            else if (sel_isw) rdata <= input_switch_reg;
            else if (sel_ist) rdata <= {6'h00, ist_reg};
            else if (sel_msk) rdata <= {6'h00, msk_reg};
            else if (sel_mode) rdata <= {5'h00, mode_reg};
            else rdata <= 8'h00;
        end else begin
            rdata <= 8'h00;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_div_reset;
        @(posedge clk) $rose(resetn) |-> baud_divider_reg == `UBK_DIV_RST;
    endproperty
    a_div_reset: assert property (p_div_reset) else $error("divider not ones after reset"); // RULE_03
    property p_div_legal;
        @(posedge clk) disable iff (!resetn) baud_divider_reg >= `UBK_DIV_MIN;
    endproperty
    a_div_legal: assert property (p_div_legal) else $error("divider below four"); // RULE_01
    property p_trig_read;
        @(posedge clk) disable iff (!resetn) rd && sel_brk |=> rdata[6:5] == 2'h0;
    endproperty
    a_trig_read: assert property (p_trig_read) else $error("trigger read nonzero"); // RULE_08
    property p_rxst_busy;
        @(posedge clk) disable iff (!resetn)
            state_reg == ubk_pkg::ubk_rx_low && !ev_rx_done && power && rxe |=> break_control_reg[7];
    endproperty
    a_rxst_busy: assert property (p_rxst_busy) else $error("rx status low in reception"); // RULE_06
    property p_rx_done;
        @(posedge clk) disable iff (!resetn) ev_rx_done |=> !break_control_reg[7] && ist_reg[1];
    endproperty
    a_rx_done: assert property (p_rx_done) else $error("rx done not reported"); // RULE_08
    property p_tx_done;
        @(posedge clk) disable iff (!resetn) ev_tx_done |=> state_reg == ubk_pkg::ubk_idle && ist_reg[0];
    endproperty
    a_tx_done: assert property (p_tx_done) else $error("tx break not ended"); // RULE_09
    property p_tx_low;
        @(posedge clk) disable iff (!resetn)
            state_reg == ubk_pkg::ubk_tx_brk |=> tx_pin_default == break_control_reg[0];
    endproperty
    a_tx_low: assert property (p_tx_low) else $error("break not driven"); // RULE_10
    property p_inv_own;
        @(posedge clk) disable iff (!resetn) break_control_reg[0] |=> !(tx_pin_default_oe_n && tx_pin_alt_oe_n);
    endproperty
    a_inv_own: assert property (p_inv_own) else $error("inverted tx pin released"); // RULE_13
    property p_route;
        @(posedge clk) disable iff (!resetn) input_switch_reg[0] |=> external_irq_input == $past(rx_level_reg);
    endproperty
    a_route: assert property (p_route) else $error("irq route wrong"); // RULE_19

    property p_tx_trig_clr;
        @(posedge clk) disable iff (!resetn) ev_tx_done && !wr |=> !break_control_reg[`UBK_BIT_TXTRG];
    endproperty
    a_tx_trig_clr: assert property (p_tx_trig_clr) else $error("tx trigger not cleared"); // RULE_09

    property p_rx_trig_clr;
        @(posedge clk) disable iff (!resetn) ev_rx_done && !wr |=> !break_control_reg[`UBK_BIT_RXTRG];
    endproperty
    a_rx_trig_clr: assert property (p_rx_trig_clr) else $error("rx trigger not cleared"); // RULE_08

    property p_rx_err_hold;
        @(posedge clk) disable iff (!resetn)
            state_reg == ubk_pkg::ubk_rx_low && power && rxe && rx_level_reg && bit_cnt_reg < `UBK_RXBRK_MIN
            |=> state_reg == ubk_pkg::ubk_rx_wait && break_control_reg[`UBK_BIT_RXST];
    endproperty
    a_rx_err_hold: assert property (p_rx_err_hold) else $error("short break not returned to wait"); // RULE_07

    property p_rxst_off;
        @(posedge clk) disable iff (!resetn) !power && !rxe |=> !break_control_reg[`UBK_BIT_RXST];
    endproperty
    a_rxst_off: assert property (p_rxst_off) else $error("rx status held while off"); // RULE_06

    property p_tick_pulse;
        @(posedge clk) disable iff (!resetn) baud_tick |=> !baud_tick;
    endproperty
    a_tick_pulse: assert property (p_tick_pulse) else $error("bit tick longer than one cycle"); // RULE_02

    property p_tx_begin;
        @(posedge clk) disable iff (!resetn)
            state_reg == ubk_pkg::ubk_idle && tx_start |=> state_reg == ubk_pkg::ubk_tx_brk;
    endproperty
    a_tx_begin: assert property (p_tx_begin) else $error("break send not started"); // RULE_09

    property p_rx_begin;
        @(posedge clk) disable iff (!resetn)
            state_reg == ubk_pkg::ubk_idle && rx_start && !tx_start |=> state_reg == ubk_pkg::ubk_rx_wait;
    endproperty
    a_rx_begin: assert property (p_rx_begin) else $error("break reception not started"); // RULE_08

    property p_swap_oe;
        @(posedge clk) disable iff (!resetn)
            input_switch_reg[`UBK_SWAP_A] || input_switch_reg[`UBK_SWAP_B] |=> tx_pin_default_oe_n;
    endproperty
    a_swap_oe: assert property (p_swap_oe) else $error("default tx pin driven while swapped"); // RULE_17

    property p_rx_gate;
        @(posedge clk) disable iff (!resetn)
            !(input_switch_reg[`UBK_SWAP_A] || input_switch_reg[`UBK_SWAP_B] || input_switch_reg[`UBK_RXEN]) |=> rxs_reg[0];
    endproperty
    a_rx_gate: assert property (p_rx_gate) else $error("disabled rx pin not ignored"); // RULE_18

    property p_cap_route;
        @(posedge clk) disable iff (!resetn)
            input_switch_reg[`UBK_CAP] |=> timer_capture_input == $past(rx_level_reg);
    endproperty
    a_cap_route: assert property (p_cap_route) else $error("capture route wrong"); // RULE_19

    property p_div_write;
        @(posedge clk) disable iff (!resetn)
            wr && sel_div && wdata >= `UBK_DIV_MIN |=> baud_divider_reg == $past(wdata);
    endproperty
    a_div_write: assert property (p_div_write) else $error("legal divider not taken"); // RULE_01

    property p_div_refuse;
        @(posedge clk) disable iff (!resetn) wr && sel_div && wdata < `UBK_DIV_MIN |=> $stable(baud_divider_reg);
    endproperty
    a_div_refuse: assert property (p_div_refuse) else $error("prohibited divider taken"); // RULE_01

    property p_brk_range;
        @(posedge clk) disable iff (!resetn) brk_len >= `UBK_BRK_BASE && brk_len <= `UBK_BRK_MAX;
    endproperty
    a_brk_range: assert property (p_brk_range) else $error("break length out of range"); // RULE_10
endmodule // ubk_top
